// ---- verilog/tcc_channel.sv ----
// Timer channel top: counter, triggers, capture loads, compares, status
`timescale 1ns/10ps
module tcc_channel
  import tcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  output logic      [31:0] rd_data,
  input  wire logic        count_edge,
  input  wire logic        block_simul_trigger,
  input  wire logic        io_line_a_in,
  output logic             io_line_a_out,
  output logic             io_line_a_oe_b,
  input  wire logic        io_line_b_in,
  output logic             io_line_b_out,
  output logic             io_line_b_oe_b,
  input  wire logic        ext_clk_0,
  input  wire logic        ext_clk_1,
  input  wire logic        ext_clk_2
);

  // Software visible state, with internal run, trigger and load flags
  logic [31:0] mode_reg;
  logic [15:0] count_reg;
  logic [15:0] reg_a_reg;
  logic [15:0] reg_b_reg;
  logic [15:0] reg_c_reg;
  logic        clk_enabled_reg;
  logic        running_reg;
  logic        trig_pending_reg;
  logic        a_done_reg;
  logic        a_unread_reg;
  logic        b_unread_reg;
  logic [7:0]  status_reg;
  logic [7:0]  status_next;

  // Decoded mode fields
  logic             wave;
  logic             c_match_trigger_en;
  logic             capture_trig_line_sel;
  tcc_edge_type     capture_trig_edge;
  tcc_edge_type     load_a_edge;
  tcc_edge_type     load_b_edge;
  logic             c_match_halt;
  logic             c_match_clk_off;
  tcc_edge_type     event_edge;
  tcc_evt_line_type event_line_sel;
  logic             event_trig_en;

  // Bus strobes
  logic wr_ctrl;
  logic wr_mode;
  logic rd_status;
  logic rd_reg_a;
  logic rd_reg_b;
  logic soft_trigger_cmd;
  logic clk_en_cmd;
  logic clk_dis_cmd;

  // Event terms
  logic [TCC_LINES-1:0] rise;
  logic [TCC_LINES-1:0] fall;
  logic        count_step;
  logic [15:0] count_next;
  logic        wrap_ev;
  logic        match_a;
  logic        match_b;
  logic        match_c;
  logic        ext_cap_ev;
  logic        ext_evt_ev;
  logic        ext_ev;
  logic        trig_soft;
  logic        trig_any;
  logic        load_a;
  logic        load_b;
  logic        c_stop;
  logic        c_off;
  logic        drive_b;
  logic        level_a;
  logic        level_b;

  assign wave                  = mode_reg[TCC_MODE_WAVE];
  assign c_match_trigger_en    = mode_reg[TCC_MODE_C_TRIG];
  assign capture_trig_line_sel = mode_reg[TCC_MODE_TRIG_LINE];
  assign capture_trig_edge     = tcc_edge_type'(mode_reg[TCC_MODE_TRIG_EDGE_LO +: 2]);
  assign load_a_edge           = tcc_edge_type'(mode_reg[TCC_MODE_LOAD_A_LO +: 2]);
  assign load_b_edge           = tcc_edge_type'(mode_reg[TCC_MODE_LOAD_B_LO +: 2]);
  assign c_match_halt          = mode_reg[TCC_MODE_C_HALT];
  assign c_match_clk_off       = mode_reg[TCC_MODE_C_CLK_OFF];
  assign event_edge            = tcc_edge_type'(mode_reg[TCC_MODE_EVT_EDGE_LO +: 2]);
  assign event_line_sel        = tcc_evt_line_type'(mode_reg[TCC_MODE_EVT_LINE_LO +: 2]);
  assign event_trig_en         = mode_reg[TCC_MODE_EVT_TRIG];

  // Edge filter shared by every edge selection field
  function automatic logic edge_hit(input tcc_edge_type sel, input logic r, input logic f);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      TCC_EDGE_NONE: hit = 1'b0;
      TCC_EDGE_RISE: hit = r;
      TCC_EDGE_FALL: hit = f;
      TCC_EDGE_BOTH: hit = r | f;
    endcase
    return hit;
  endfunction : edge_hit

  // Register access decode
  assign wr_ctrl          = wr_strobe && (addr == TCC_OFF_CTRL);
  assign wr_mode          = wr_strobe && (addr == TCC_OFF_MODE);
  assign rd_status        = rd_strobe && (addr == TCC_OFF_STATUS);
  assign rd_reg_a         = rd_strobe && (addr == TCC_OFF_REG_A);
  assign rd_reg_b         = rd_strobe && (addr == TCC_OFF_REG_B);
  assign soft_trigger_cmd = wr_ctrl && wr_data[TCC_CTRL_SOFT_TRIG];
  assign clk_en_cmd       = wr_ctrl && wr_data[TCC_CTRL_CLK_EN];
  assign clk_dis_cmd      = wr_ctrl && wr_data[TCC_CTRL_CLK_DIS];

  // All external lines cross into the master clock here
  tcc_sync_edge #(
    .WIDTH (TCC_LINES)
  ) u_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .line_in ({ext_clk_2, ext_clk_1, ext_clk_0, io_line_b_in, io_line_a_in}),
    .rise    (rise),
    .fall    (fall)
  );

  // Counter step: a pending trigger turns the next active edge into a clear
  assign count_step = count_edge && running_reg;
  assign count_next = trig_pending_reg ? TCC_VALUE_RESET : 16'(count_reg + 16'h0001);
  assign wrap_ev    = count_step && !trig_pending_reg && (count_reg == TCC_COUNT_LAST);

  // Compares are judged on the value the counter is about to take
  assign match_c = count_step && (count_next == reg_c_reg);
  assign match_a = count_step && wave && (count_next == reg_a_reg);
  assign match_b = count_step && wave && (count_next == reg_b_reg);

  // Capture external trigger on the chosen line
  always_comb begin
    if (capture_trig_line_sel) begin
      ext_cap_ev = !wave && edge_hit(capture_trig_edge, rise[TCC_LN_A], fall[TCC_LN_A]);
    end else begin
      ext_cap_ev = !wave && edge_hit(capture_trig_edge, rise[TCC_LN_B], fall[TCC_LN_B]);
    end
  end

  // Waveform external event on the chosen line
  always_comb begin
    unique case (event_line_sel)
      TCC_EVT_LINE_B: ext_evt_ev = edge_hit(event_edge, rise[TCC_LN_B], fall[TCC_LN_B]);
      TCC_EVT_X0:     ext_evt_ev = edge_hit(event_edge, rise[TCC_LN_X0], fall[TCC_LN_X0]);
      TCC_EVT_X1:     ext_evt_ev = edge_hit(event_edge, rise[TCC_LN_X1], fall[TCC_LN_X1]);
      TCC_EVT_X2:     ext_evt_ev = edge_hit(event_edge, rise[TCC_LN_X2], fall[TCC_LN_X2]);
    endcase
  end

  assign ext_ev = wave ? ext_evt_ev : ext_cap_ev;

  // Trigger sources merged; the block input counts as a software trigger
  assign trig_soft = soft_trigger_cmd || block_simul_trigger;
  assign trig_any  = trig_soft
                  || (match_c && c_match_trigger_en)
                  || ext_cap_ev
                  || (wave && ext_evt_ev && event_trig_en);

  // Waveform stop terms from the C compare
  assign c_stop = wave && match_c && c_match_halt;
  assign c_off  = wave && match_c && c_match_clk_off;

  // Capture loads, alternating A then B between triggers
  assign load_a = !wave && !a_done_reg
               && edge_hit(load_a_edge, rise[TCC_LN_A], fall[TCC_LN_A]);
  assign load_b = !wave && a_done_reg
               && edge_hit(load_b_edge, rise[TCC_LN_A], fall[TCC_LN_A]);

  // Mode word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= TCC_MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= wr_data;
    end
  end

  // Clock enable: disable beats enable, as does a C match with clock off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_enabled_reg <= 1'b0;
    end else if (clk_dis_cmd || c_off) begin
      clk_enabled_reg <= 1'b0;
    end else if (clk_en_cmd) begin
      clk_enabled_reg <= 1'b1;
    end
  end

  // Start and stop act only while enabled, an enable in the same write included; stop beats start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      running_reg <= 1'b0;
    end else if ((!clk_enabled_reg && !clk_en_cmd) || clk_dis_cmd || c_off) begin
      running_reg <= 1'b0;
    end else if (c_stop) begin
      running_reg <= 1'b0;
    end else if (trig_any) begin
      running_reg <= 1'b1;
    end
  end

  // Pending trigger waits for the next counting edge; a new one wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_pending_reg <= 1'b0;
    end else begin
      trig_pending_reg <= trig_any || (trig_pending_reg && !count_step);
    end
  end

  // Counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= TCC_VALUE_RESET;
    end else if (count_step) begin
      count_reg <= count_next;
    end
  end

  // Load sequencing; a trigger rearms reg_a
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_done_reg <= 1'b0;
    end else if (trig_any) begin
      a_done_reg <= 1'b0;
    end else if (load_a) begin
      a_done_reg <= 1'b1;
    end else if (load_b) begin
      a_done_reg <= 1'b0;
    end
  end

  // Unread tracking for overrun; a load in the read cycle keeps it set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_unread_reg <= 1'b0;
      b_unread_reg <= 1'b0;
    end else begin
      a_unread_reg <= load_a || (a_unread_reg && !rd_reg_a);
      b_unread_reg <= load_b || (b_unread_reg && !rd_reg_b);
    end
  end

  // Compare and capture registers; A and B are writable only in waveform
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_a_reg <= TCC_VALUE_RESET;
      reg_b_reg <= TCC_VALUE_RESET;
      reg_c_reg <= TCC_VALUE_RESET;
    end else begin
      if (load_a) begin
        reg_a_reg <= count_reg;
      end else if (wave && wr_strobe && (addr == TCC_OFF_REG_A)) begin
        reg_a_reg <= wr_data[15:0];
      end
      if (load_b) begin
        reg_b_reg <= count_reg;
      end else if (wave && wr_strobe && (addr == TCC_OFF_REG_B)) begin
        reg_b_reg <= wr_data[15:0];
      end
      if (wr_strobe && (addr == TCC_OFF_REG_C)) begin
        reg_c_reg <= wr_data[15:0];
      end
    end
  end

  // Status events; flags meaningful in the other mode stay quiet
  always_comb begin
    status_next = '0;
    status_next[TCC_ST_WRAP]     = wrap_ev;
    status_next[TCC_ST_OVERRUN]  = (load_a && a_unread_reg) || (load_b && b_unread_reg);
    status_next[TCC_ST_A_MATCH]  = match_a;
    status_next[TCC_ST_B_MATCH]  = match_b;
    status_next[TCC_ST_C_MATCH]  = match_c;
    status_next[TCC_ST_A_LOADED] = load_a;
    status_next[TCC_ST_B_LOADED] = load_b;
    status_next[TCC_ST_EXT_TRIG] = ext_ev;
  end

  // Sticky flags; an event in the read cycle survives the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= '0;
    end else if (rd_status) begin
      status_reg <= status_next;
    end else begin
      status_reg <= status_reg | status_next;
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else if (rd_strobe) begin
      unique case (addr)
        TCC_OFF_MODE:   rd_data <= mode_reg;
        TCC_OFF_COUNT:  rd_data <= {16'h0000, count_reg};
        TCC_OFF_REG_A:  rd_data <= {16'h0000, reg_a_reg};
        TCC_OFF_REG_B:  rd_data <= {16'h0000, reg_b_reg};
        TCC_OFF_REG_C:  rd_data <= {16'h0000, reg_c_reg};
        TCC_OFF_STATUS: rd_data <= {15'h0000, clk_enabled_reg, 8'h00, status_reg};
        default:        rd_data <= '0;
      endcase
    end else begin
      rd_data <= '0;
    end
  end

  // Line B is an output only in waveform and when not the event line
  assign drive_b = wave && (event_line_sel != TCC_EVT_LINE_B);

  // Line A waveform
  tcc_out_ctl u_out_a (
    .clk      (clk),
    .rst_b    (rst_b),
    .active   (wave),
    .ev_soft  (trig_soft),
    .ev_ext   (ext_evt_ev),
    .ev_c     (match_c),
    .ev_own   (match_a),
    .act_soft (tcc_action_type'(mode_reg[TCC_MODE_A_ON_SOFT_LO +: 2])),
    .act_ext  (tcc_action_type'(mode_reg[TCC_MODE_A_ON_EVT_LO +: 2])),
    .act_c    (tcc_action_type'(mode_reg[TCC_MODE_A_ON_C_LO +: 2])),
    .act_own  (tcc_action_type'(mode_reg[TCC_MODE_A_ON_A_LO +: 2])),
    .level    (level_a)
  );

  // Line B waveform; the event on B itself never drives B
  tcc_out_ctl u_out_b (
    .clk      (clk),
    .rst_b    (rst_b),
    .active   (drive_b),
    .ev_soft  (trig_soft),
    .ev_ext   (ext_evt_ev),
    .ev_c     (match_c),
    .ev_own   (match_b),
    .act_soft (tcc_action_type'(mode_reg[TCC_MODE_B_ON_SOFT_LO +: 2])),
    .act_ext  (tcc_action_type'(mode_reg[TCC_MODE_B_ON_EVT_LO +: 2])),
    .act_c    (tcc_action_type'(mode_reg[TCC_MODE_B_ON_C_LO +: 2])),
    .act_own  (tcc_action_type'(mode_reg[TCC_MODE_B_ON_B_LO +: 2])),
    .level    (level_b)
  );

  // Pin outputs from flip-flops; enables low while driving
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_line_a_out  <= 1'b0;
      io_line_a_oe_b <= 1'b1;
      io_line_b_out  <= 1'b0;
      io_line_b_oe_b <= 1'b1;
    end else begin
      io_line_a_out  <= level_a;
      io_line_a_oe_b <= !wave;
      io_line_b_out  <= level_b;
      io_line_b_oe_b <= !drive_b;
    end
  end

endmodule : tcc_channel

// ---- verilog/tcc_pkg.sv ----
// Constants, field layout and types for the timer capture/waveform channel
//
// Function
// - Mode bit selects capture or waveform; capture makes both lines inputs.
// - Waveform drives line A always, line B unless it is the event line.
// - Any trigger resets the counter and starts the counting clock.
// - Writing the soft trigger bit in the control word triggers the channel.
// - Block simultaneous trigger input behaves exactly like a software trigger.
// - With C-match trigger enabled, counter equal to reg_c triggers, both modes.
// - Capture: select line A or B and edge for external trigger; zero disables.
// - A trigger takes effect at the next active counting edge.
// - Capture: line A edges chosen per register load reg_a or reg_b.
// - reg_a loads only if unloaded since trigger or reg_b loaded since.
// - reg_b loads only if reg_a loaded since trigger or last reg_b load.
// - Reloading before read sets load overrun and overwrites the value.
// - Capture status: C match, wrap, overrun, A loaded, B loaded, external trigger.
// - Status flags set on event and all clear when status is read; a flag whose event falls in the read cycle stays set.
// - Waveform: A, B, C are compare values steering the two lines.
// - Waveform: C match halts or disables the counting clock when selected.
// - Waveform: select event line and edge; zero edge means no event.
// - Event line zero picks line B; B then undriven, waveform on A only.
// - With event trigger enabled, each detected event is a trigger.
// - Per-line action fields set, clear or toggle on each output event.
// - Coinciding events apply only the highest priority action.
// - Waveform status: A, B, C matches, wrap, external triggers.
// - 16-bit counter increments per counting edge; FFFF to 0 sets wrap.
// - Start and stop have no effect while the counting clock is disabled.
package tcc_pkg;

  // Register byte offsets
  localparam logic [7:0] TCC_OFF_CTRL     = 8'h00;
  localparam logic [7:0] TCC_OFF_MODE     = 8'h04;
  localparam logic [7:0] TCC_OFF_COUNT    = 8'h10;
  localparam logic [7:0] TCC_OFF_REG_A    = 8'h14;
  localparam logic [7:0] TCC_OFF_REG_B    = 8'h18;
  localparam logic [7:0] TCC_OFF_REG_C    = 8'h1c;
  localparam logic [7:0] TCC_OFF_STATUS   = 8'h20;

  // Reset values and last count before wrap
  localparam logic [31:0] TCC_MODE_RESET  = 32'h0000_0000;
  localparam logic [15:0] TCC_VALUE_RESET = 16'h0000;
  localparam logic [15:0] TCC_COUNT_LAST  = 16'hffff;

  // Control word bits
  localparam int TCC_CTRL_CLK_EN          = 0;
  localparam int TCC_CTRL_CLK_DIS         = 1;
  localparam int TCC_CTRL_SOFT_TRIG       = 2;

  // Mode word fields common to both modes
  localparam int TCC_MODE_C_TRIG          = 14;
  localparam int TCC_MODE_WAVE            = 15;
  // Capture mode fields
  localparam int TCC_MODE_TRIG_EDGE_LO    = 8;
  localparam int TCC_MODE_TRIG_LINE       = 10;
  localparam int TCC_MODE_LOAD_A_LO       = 16;
  localparam int TCC_MODE_LOAD_B_LO       = 18;
  // Waveform mode fields
  localparam int TCC_MODE_C_HALT          = 6;
  localparam int TCC_MODE_C_CLK_OFF       = 7;
  localparam int TCC_MODE_EVT_EDGE_LO     = 8;
  localparam int TCC_MODE_EVT_LINE_LO     = 10;
  localparam int TCC_MODE_EVT_TRIG        = 12;
  localparam int TCC_MODE_A_ON_A_LO       = 16;
  localparam int TCC_MODE_A_ON_C_LO       = 18;
  localparam int TCC_MODE_A_ON_EVT_LO     = 20;
  localparam int TCC_MODE_A_ON_SOFT_LO    = 22;
  localparam int TCC_MODE_B_ON_B_LO       = 24;
  localparam int TCC_MODE_B_ON_C_LO       = 26;
  localparam int TCC_MODE_B_ON_EVT_LO     = 28;
  localparam int TCC_MODE_B_ON_SOFT_LO    = 30;

  // Status word bits
  localparam int TCC_ST_WRAP              = 0;
  localparam int TCC_ST_OVERRUN           = 1;
  localparam int TCC_ST_A_MATCH           = 2;
  localparam int TCC_ST_B_MATCH           = 3;
  localparam int TCC_ST_C_MATCH           = 4;
  localparam int TCC_ST_A_LOADED          = 5;
  localparam int TCC_ST_B_LOADED          = 6;
  localparam int TCC_ST_EXT_TRIG          = 7;
  localparam int TCC_ST_CLK_ENABLED       = 16;

  // Synchronised input line indices
  localparam int TCC_LN_A                 = 0;
  localparam int TCC_LN_B                 = 1;
  localparam int TCC_LN_X0                = 2;
  localparam int TCC_LN_X1                = 3;
  localparam int TCC_LN_X2                = 4;
  localparam int TCC_LINES                = 5;

  // Output action encoding
  typedef enum logic [1:0] {
    TCC_ACT_NONE   = 2'b00,
    TCC_ACT_SET    = 2'b01,
    TCC_ACT_CLEAR  = 2'b10,
    TCC_ACT_TOGGLE = 2'b11
  } tcc_action_type;

  // Edge selection encoding
  typedef enum logic [1:0] {
    TCC_EDGE_NONE  = 2'b00,
    TCC_EDGE_RISE  = 2'b01,
    TCC_EDGE_FALL  = 2'b10,
    TCC_EDGE_BOTH  = 2'b11
  } tcc_edge_type;

  // Waveform event line selection
  typedef enum logic [1:0] {
    TCC_EVT_LINE_B = 2'b00,
    TCC_EVT_X0     = 2'b01,
    TCC_EVT_X1     = 2'b10,
    TCC_EVT_X2     = 2'b11
  } tcc_evt_line_type;

endpackage : tcc_pkg

// ---- verilog/tcc_sync_edge.sv ----
// Two-flop synchroniser with rise and fall detection for a group of lines
`timescale 1ns/10ps
module tcc_sync_edge #(
  parameter int WIDTH = 5
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] line_in,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  import tcc_pkg::*;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;
  logic [2:0]       warm_reg;

  // Only sync_reg reads meta_reg; edges come from the settled stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
      warm_reg <= '0;
    end else begin
      warm_reg <= {warm_reg[1:0], 1'b1};
      meta_reg <= line_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edge pulses, masked until the stages fill, so a high idle pin gives no false rise
  assign rise = sync_reg & ~prev_reg & {WIDTH{warm_reg[2]}};
  assign fall = ~sync_reg & prev_reg & {WIDTH{warm_reg[2]}};

endmodule : tcc_sync_edge

// ---- verilog/tcc_out_ctl.sv ----
// Output level controller for one waveform line with prioritised actions
`timescale 1ns/10ps
module tcc_out_ctl (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           active,
  input  wire logic           ev_soft,
  input  wire logic           ev_ext,
  input  wire logic           ev_c,
  input  wire logic           ev_own,
  input  wire tcc_pkg::tcc_action_type act_soft,
  input  wire tcc_pkg::tcc_action_type act_ext,
  input  wire tcc_pkg::tcc_action_type act_c,
  input  wire tcc_pkg::tcc_action_type act_own,
  output logic                level
);
  import tcc_pkg::*;

  tcc_action_type act_sel;

  // Highest priority event wins, lower ones are dropped
  always_comb begin
    if (ev_soft) begin
      act_sel = act_soft;
    end else if (ev_ext) begin
      act_sel = act_ext;
    end else if (ev_c) begin
      act_sel = act_c;
    end else if (ev_own) begin
      act_sel = act_own;
    end else begin
      act_sel = TCC_ACT_NONE;
    end
  end

  // Level held while inactive so a mode switch keeps the last waveform value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= 1'b0;
    end else if (active) begin
      unique case (act_sel)
        TCC_ACT_NONE:   level <= level;
        TCC_ACT_SET:    level <= 1'b1;
        TCC_ACT_CLEAR:  level <= 1'b0;
        TCC_ACT_TOGGLE: level <= ~level;
      endcase
    end
  end

endmodule : tcc_out_ctl

// ---- verif/tcc_channel_asserts.sv ----
// Port checker for the timer channel, bound into its top
`timescale 1ns/10ps
module tcc_channel_asserts
  import tcc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_strobe,
  input wire logic        rd_strobe,
  input wire logic [31:0] rd_data,
  input wire logic        block_simul_trigger,
  input wire logic        io_line_a_out,
  input wire logic        io_line_a_oe_b,
  input wire logic        io_line_b_out,
  input wire logic        io_line_b_oe_b
);
  logic [31:0] mode_reg;
  logic [1:0]  age_reg;
  logic        cp;
  logic        wv;
  // Mode shadow; outputs lag a mode write, so judge them once it has aged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= 32'h0;
      age_reg  <= 2'h0;
    end else if (wr_strobe && addr == TCC_OFF_MODE) begin
      mode_reg <= wr_data;
      age_reg  <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  assign cp = age_reg == 2'h3 && !mode_reg[TCC_MODE_WAVE];
  assign wv = age_reg == 2'h3 && mode_reg[TCC_MODE_WAVE];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_CAP_IN: assert property (cp |-> io_line_a_oe_b && io_line_b_oe_b)
    else $error("line driven in capture");
  AST_A_OUT: assert property (wv |-> !io_line_a_oe_b)
    else $error("line a not driven");
  AST_B_EVT: assert property (wv |-> io_line_b_oe_b == (mode_reg[11:10] == 2'h0))
    else $error("line b drive wrong");
  AST_MODE_RB: assert property ($past(rd_strobe && addr == TCC_OFF_MODE) |-> rd_data == $past(mode_reg))
    else $error("mode readback");
  AST_CTRL_WO: assert property ($past(rd_strobe && addr == TCC_OFF_CTRL) |-> rd_data == 32'h0)
    else $error("control read not zero");
  AST_HALF: assert property ($past(rd_strobe && addr[7:4] == 4'h1) |-> rd_data[31:16] == 16'h0)
    else $error("upper half not zero");
  AST_SOFT_A: assert property (wv && wr_strobe && addr == TCC_OFF_CTRL && wr_data[2:0] == 3'h5
    && mode_reg[23:22] == 2'h1 |-> ##[1:3] io_line_a_out) else $error("soft set missing");
  AST_SYNC_B: assert property (wv && block_simul_trigger && mode_reg[31:30] == 2'h2
    && mode_reg[11:10] != 2'h0 |-> ##[1:3] !io_line_b_out) else $error("block trigger clear missing");
  cover property (wv && block_simul_trigger);
  cover property ($past(rd_strobe && addr == TCC_OFF_STATUS) && rd_data[5]);
  cover property (wv && io_line_b_oe_b);
endmodule : tcc_channel_asserts
bind tcc_channel tcc_channel_asserts tcc_channel_asserts_inst (.clk, .rst_b, .addr, .wr_data, .wr_strobe,
  .rd_strobe, .rd_data, .block_simul_trigger, .io_line_a_out, .io_line_a_oe_b, .io_line_b_out, .io_line_b_oe_b);

// ---- verif/tcc_line_model.sv ----
// Far-side signal source with wire resolution for both channel pins
`timescale 1ns/10ps
module tcc_line_model (
  input  wire logic a_out,
  input  wire logic a_oe_b,
  input  wire logic b_out,
  input  wire logic b_oe_b,
  input  wire logic a_drv,
  input  wire logic b_drv,
  output logic      a_wire,
  output logic      b_wire
);
  // Channel wins while it drives; otherwise the far side sets the level
  assign a_wire = a_oe_b ? a_drv : a_out;
  assign b_wire = b_oe_b ? b_drv : b_out;
endmodule : tcc_line_model

// ---- verif/tb.sv ----
// Self-checking bench for the timer capture/waveform channel
`timescale 1ns/10ps
module tb;
  import tcc_pkg::*;
  logic        clk, rst_b, wr_strobe, rd_strobe, count_edge, sync_trig, a_drv, b_drv, x0;
  logic        a_wire, b_wire, a_out, a_oe_b, b_out, b_oe_b;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data, q, v;
  int          fail_count, checked;
  tcc_channel tcc_channel_inst (.clk, .rst_b, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data, .count_edge,
    .block_simul_trigger(sync_trig), .io_line_a_in(a_wire), .io_line_a_out(a_out), .io_line_a_oe_b(a_oe_b),
    .io_line_b_in(b_wire), .io_line_b_out(b_out), .io_line_b_oe_b(b_oe_b), .ext_clk_0(x0),
    .ext_clk_1(x0), .ext_clk_2(x0));
  tcc_line_model tcc_line_model_inst (.a_out, .a_oe_b, .b_out, .b_oe_b, .a_drv, .b_drv, .a_wire, .b_wire);
  // Bus cycles; a gap cycle keeps strobes from being assigned twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr      <= a;
    wr_data   <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr      <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 d = rd_data;
    @(posedge clk);
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Counting edges, then time for synchroniser and pin flops to settle
  task automatic tick(input int n);
    repeat (n) begin
      count_edge <= 1'b1;
      @(posedge clk);
      count_edge <= 1'b0;
      @(posedge clk);
    end
    repeat (5) @(posedge clk);
  endtask : tick
  task automatic line(input logic l);
    a_drv <= l;
    tick(0);
  endtask : line
  task automatic sync;
    sync_trig <= 1'b1;
    @(posedge clk);
    sync_trig <= 1'b0;
    tick(0);
  endtask : sync
  // Counter value after a trigger and n counting edges
  function automatic logic [31:0] cnt(input int n);
    return 32'(n - 1);
  endfunction : cnt
  task automatic end_of_test;
    $display("counts: %0d checked, %0d wrong", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  initial begin
    {rst_b, wr_strobe, rd_strobe, count_edge, sync_trig, a_drv, x0} = 7'h0;
    b_drv = 1'b1;
    addr = 8'h0;
    wr_data = 32'h0;
    fail_count = 0;
    checked = 0;
    void'($urandom(8));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Random capture modes and compare values; reg_a is read-only here
    repeat (4) begin
      v = $urandom() & 32'h000f_0700;
      wr(TCC_OFF_MODE, v);
      rd(TCC_OFF_MODE, q);
      chk(q, v);
      v = $urandom() & 32'hffff;
      wr(TCC_OFF_REG_C, v);
      wr(TCC_OFF_REG_A, ~v);
      rd(TCC_OFF_REG_C, q);
      chk(q, v);
      rd(TCC_OFF_REG_A, q);
      chk(q, 32'h0);
    end
    rd(TCC_OFF_CTRL, q);
    rd(8'h08, q);
    chk(q, 32'h0);
    $display("registers done");
    // Capture: A on rising, B on falling edge; second A load overruns
    wr(TCC_OFF_MODE, 32'h0009_0000);
    wr(TCC_OFF_REG_C, 32'h100);
    wr(TCC_OFF_CTRL, 32'h5);
    tick(4);
    line(1);
    tick(2);
    line(0);
    tick(2);
    line(1);
    tick(1);
    line(0);
    rd(TCC_OFF_STATUS, q);
    chk(q & 32'h1_00f3, 32'h1_0062);
    rd(TCC_OFF_STATUS, q);
    chk(q & 32'h1_00f3, 32'h1_0000);
    rd(TCC_OFF_REG_A, q);
    chk(q, cnt(8));
    rd(TCC_OFF_REG_B, q);
    chk(q, cnt(9));
    line(1);
    sync();
    tick(2);
    line(0);
    tick(1);
    line(1);
    rd(TCC_OFF_REG_B, q);
    chk(q, cnt(9));
    rd(TCC_OFF_REG_A, q);
    chk(q, cnt(3));
    $display("capture done");
    // Waveform: A toggles on reg_a, sets on reg_c, which also restarts
    wr(TCC_OFF_MODE, 32'h9047_d500);
    wr(TCC_OFF_REG_A, 32'h2);
    wr(TCC_OFF_REG_B, 32'hff);
    wr(TCC_OFF_REG_C, 32'h4);
    wr(TCC_OFF_CTRL, 32'h5);
    tick(0);
    chk(a_out, 1);
    tick(3);
    chk(a_out, 0);
    tick(2);
    chk(a_out, 1);
    tick(3);
    chk(a_out, 0);
    rd(TCC_OFF_COUNT, q);
    chk(q, cnt(3));
    rd(TCC_OFF_STATUS, q);
    chk(q & 32'h1_009d, 32'h1_0014);
    x0 <= 1'b1;
    tick(0);
    chk(b_out, 1);
    rd(TCC_OFF_COUNT, q);
    chk(q, cnt(3));
    tick(1);
    rd(TCC_OFF_COUNT, q);
    chk(q, cnt(1));
    rd(TCC_OFF_STATUS, q);
    chk(q & 32'h80, 32'h80);
    // Block trigger, then reg_a and reg_c matches on the same count
    x0 <= 1'b0;
    wr(TCC_OFF_REG_A, 32'h4);
    sync();
    chk(b_out, 0);
    tick(5);
    chk(a_out, 1);
    wr(TCC_OFF_MODE, 32'h9047_d100);
    tick(0);
    chk(b_oe_b, 1);
    chk(a_oe_b, 0);
    $display("waveform done");
    end_of_test();
  end
endmodule : tb
